//--- rtl/clrm_consts.vh
// Constants for the control loop routing register bank
// Contract
// [RULE_01] Per-filter 2-bit constant select; codes 0..2 pick constant a/b/c; reset 0.
// [RULE_02] Filter 2 feedforward: clear takes filter 0, set takes filter 1.
// [RULE_03] Filter 1 feedforward: clear takes filter 0, set takes filter 2.
// [RULE_04] Filter 0 feedforward: clear takes filter 1, set takes filter 2.
// [RULE_05] Per-filter 2-bit period source picks generator 0..3 period; reset 0.
// [RULE_06] Per-filter front-end select codes 0..2; reset feeds filter n from front end n.
// [RULE_07] Three 14-bit substitute constants replace the switching period.
// [RULE_08] Constant b at 29:16, a at 13:0; a resets to 0x7D.
// [RULE_09] Ramp fields 31:24, sync fields 19:12, duty fields 11:0 reset generators 0..3 to 0,1,2,0.
// [RULE_10] Master-sync codes 0..3 select generators 0..3 as sync master.
// [RULE_11] Duty codes 0..2 filters, 3 constant power, 4 light-load on-time.
// [RULE_12] Ramp source codes 0..2 select front end ramp 0..2.
// [RULE_13] Reserved bits read zero, ignore writes; unlisted codes are reserved.
`ifndef CLRM_CONSTS_VH
`define CLRM_CONSTS_VH

// ==========================================================
// Register offsets
`define CLRM_ADDR_W        18
`define CLRM_OFS_FILT_MUX  18'h20014
`define CLRM_OFS_CONST_AB  18'h20018
`define CLRM_OFS_CONST_C   18'h2001C
`define CLRM_OFS_PWM_MUX   18'h20020

// ==========================================================
// Writable masks
`define CLRM_MASK_FILT_MUX 32'h3F073F3F
`define CLRM_MASK_CONST_AB 32'h3FFF3FFF
`define CLRM_MASK_CONST_C  32'h00003FFF
`define CLRM_MASK_PWM_MUX  32'hFF0FFFFF

// ==========================================================
// Reset values
`define CLRM_RST_FILT_MUX  32'h00000024
`define CLRM_RST_CONST_AB  32'h0000007D
`define CLRM_RST_CONST_C   32'h00000000
`define CLRM_RST_PWM_MUX   32'h00000088

// ==========================================================
// Field positions
`define CLRM_FM_CSEL_LSB   24
`define CLRM_FM_FFWD_LSB   16
`define CLRM_FM_PER_LSB    8
`define CLRM_FM_FE_LSB     0
`define CLRM_CB_LSB        16
`define CLRM_PM_RAMP_LSB   24
`define CLRM_PM_SYNC_LSB   12
`define CLRM_PM_DUTY_LSB   0

// ==========================================================
// Code values
`define CLRM_DUTY_CPOWER   3'h3
`define CLRM_DUTY_ONTIME   3'h4

`endif

//--- rtl/clrm_reg.v
// Masked configuration word register
module clrm_reg #(
  parameter [31:0] MASK  = 32'hFFFFFFFF,
  parameter [31:0] RST   = 32'h00000000
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        wr,
  input  wire [31:0] wdata,
  output reg  [31:0] q_ff
);
  wire [31:0] nxt_q;

  assign nxt_q = wr ? (wdata & MASK) : q_ff; // [RULE_13]

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= RST;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule

//--- rtl/clrm_top.v
// Control loop routing register bank and data path selects
//
// Added by the designer: the strobed register port.
`include "clrm_consts.vh"
module clrm_top #(
  parameter DW = 14
) (
  input  wire                    CORE_CLK,
  input  wire                    RST_N,
  input  wire [`CLRM_ADDR_W-1:0] ADDR,
  input  wire [31:0]             WDATA,
  input  wire                    WR_STB,
  input  wire                    RD_STB,
  output reg  [31:0]             RDATA,
  input  wire [3*DW-1:0]         FE_DATA,
  input  wire [3*DW-1:0]         FE_RAMP,
  input  wire [4*DW-1:0]         GEN_PERIOD,
  input  wire [3*DW-1:0]         FILT_OUT,
  input  wire [3:0]              GEN_SYNC,
  input  wire [DW-1:0]           CPOWER_OUT,
  input  wire [DW-1:0]           LIGHT_LOAD_ON_TIME,
  output reg  [3*DW-1:0]         FILT_FE_DATA,
  output reg  [3*DW-1:0]         FILT_PERIOD,
  output reg  [3*14-1:0]         FILT_CONST,
  output reg  [3*DW-1:0]         FILT_FFWD,
  output reg  [4*DW-1:0]         GEN_DUTY,
  output reg  [3:0]              GEN_MASTER_SYNC,
  output reg  [4*DW-1:0]         GEN_RAMP
);

  // ========================================================
  // Register file
  wire [31:0] filt_mux;
  wire [31:0] const_ab;
  wire [31:0] const_c;
  wire [31:0] pwm_mux;
  wire        wr_fm;
  wire        wr_ab;
  wire        wr_c;
  wire        wr_pm;

  assign wr_fm = WR_STB && (ADDR == `CLRM_OFS_FILT_MUX);
  assign wr_ab = WR_STB && (ADDR == `CLRM_OFS_CONST_AB);
  assign wr_c  = WR_STB && (ADDR == `CLRM_OFS_CONST_C);
  assign wr_pm = WR_STB && (ADDR == `CLRM_OFS_PWM_MUX);

  clrm_reg #(
    .MASK (`CLRM_MASK_FILT_MUX),
    .RST  (`CLRM_RST_FILT_MUX)
  ) u_filt_mux (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .wr    (wr_fm),
    .wdata (WDATA),
    .q_ff  (filt_mux)
  );

  clrm_reg #(
    .MASK (`CLRM_MASK_CONST_AB),
    .RST  (`CLRM_RST_CONST_AB)
  ) u_const_ab (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .wr    (wr_ab),
    .wdata (WDATA),
    .q_ff  (const_ab)
  );

  clrm_reg #(
    .MASK (`CLRM_MASK_CONST_C),
    .RST  (`CLRM_RST_CONST_C)
  ) u_const_c (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .wr    (wr_c),
    .wdata (WDATA),
    .q_ff  (const_c)
  );

  clrm_reg #(
    .MASK (`CLRM_MASK_PWM_MUX),
    .RST  (`CLRM_RST_PWM_MUX)
  ) u_pwm_mux (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .wr    (wr_pm),
    .wdata (WDATA),
    .q_ff  (pwm_mux)
  );

  // ========================================================
  // Read port
  reg [31:0] nxt_rdata;

  always @* begin
    nxt_rdata = 32'h00000000;
    if (RD_STB) begin
      case (ADDR)
        `CLRM_OFS_FILT_MUX: nxt_rdata = filt_mux;
        `CLRM_OFS_CONST_AB: nxt_rdata = const_ab; // [RULE_08]
        `CLRM_OFS_CONST_C:  nxt_rdata = const_c;
        `CLRM_OFS_PWM_MUX:  nxt_rdata = pwm_mux;
        default:            nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 32'h00000000;
    end else begin
      RDATA <= nxt_rdata;
    end
  end

  // ========================================================
  // Substitute constants
  wire [13:0] const_a;
  wire [13:0] const_b;
  wire [13:0] const_cc;

  assign const_a  = const_ab[13:0];                        // [RULE_07]
  assign const_b  = const_ab[`CLRM_CB_LSB+13:`CLRM_CB_LSB]; // [RULE_08]
  assign const_cc = const_c[13:0];                         // [RULE_07]

  // ========================================================
  // Filter side selects
  reg [3*DW-1:0] nxt_fe;
  reg [3*DW-1:0] nxt_per;
  reg [3*14-1:0] nxt_const;
  reg [3*DW-1:0] nxt_ffwd;
  reg [1:0]      sel;
  integer        f;

  always @* begin
    nxt_fe    = {3*DW{1'b0}};
    nxt_per   = {3*DW{1'b0}};
    nxt_const = {3*14{1'b0}};
    nxt_ffwd  = {3*DW{1'b0}};
    sel       = 2'h0;
    for (f = 0; f < 3; f = f + 1) begin
      sel = filt_mux[`CLRM_FM_FE_LSB+2*f +: 2];
      case (sel)
        2'h0:    nxt_fe[DW*f +: DW] = FE_DATA[0 +: DW];    // [RULE_06]
        2'h1:    nxt_fe[DW*f +: DW] = FE_DATA[DW +: DW];   // [RULE_06]
        2'h2:    nxt_fe[DW*f +: DW] = FE_DATA[2*DW +: DW]; // [RULE_06]
        default: nxt_fe[DW*f +: DW] = {DW{1'b0}};          // [RULE_13]
      endcase
      sel = filt_mux[`CLRM_FM_PER_LSB+2*f +: 2];
      nxt_per[DW*f +: DW] = GEN_PERIOD[DW*sel +: DW];      // [RULE_05]
      sel = filt_mux[`CLRM_FM_CSEL_LSB+2*f +: 2];
      case (sel)
        2'h0:    nxt_const[14*f +: 14] = const_a;          // [RULE_01]
        2'h1:    nxt_const[14*f +: 14] = const_b;          // [RULE_01]
        2'h2:    nxt_const[14*f +: 14] = const_cc;         // [RULE_01]
        default: nxt_const[14*f +: 14] = 14'h0000;         // [RULE_13]
      endcase
    end
    nxt_ffwd[0 +: DW] = filt_mux[`CLRM_FM_FFWD_LSB] ?
      FILT_OUT[2*DW +: DW] : FILT_OUT[DW +: DW];           // [RULE_04]
    nxt_ffwd[DW +: DW] = filt_mux[`CLRM_FM_FFWD_LSB+1] ?
      FILT_OUT[2*DW +: DW] : FILT_OUT[0 +: DW];            // [RULE_03]
    nxt_ffwd[2*DW +: DW] = filt_mux[`CLRM_FM_FFWD_LSB+2] ?
      FILT_OUT[DW +: DW] : FILT_OUT[0 +: DW];              // [RULE_02]
  end

  // ========================================================
  // Generator side selects
  reg [4*DW-1:0] nxt_duty;
  reg [3:0]      nxt_sync;
  reg [4*DW-1:0] nxt_ramp;
  reg [2:0]      dsel;
  reg [1:0]      gsel;
  integer        g;

  always @* begin
    nxt_duty = {4*DW{1'b0}};
    nxt_sync = 4'h0;
    nxt_ramp = {4*DW{1'b0}};
    dsel     = 3'h0;
    gsel     = 2'h0;
    for (g = 0; g < 4; g = g + 1) begin
      dsel = pwm_mux[`CLRM_PM_DUTY_LSB+3*g +: 3];
      case (dsel)
        3'h0: nxt_duty[DW*g +: DW] = FILT_OUT[0 +: DW];    // [RULE_11]
        3'h1: nxt_duty[DW*g +: DW] = FILT_OUT[DW +: DW];   // [RULE_11]
        3'h2: nxt_duty[DW*g +: DW] = FILT_OUT[2*DW +: DW]; // [RULE_11]
        `CLRM_DUTY_CPOWER:
          nxt_duty[DW*g +: DW] = CPOWER_OUT;               // [RULE_11]
        `CLRM_DUTY_ONTIME:
          nxt_duty[DW*g +: DW] = LIGHT_LOAD_ON_TIME;       // [RULE_11]
        default: nxt_duty[DW*g +: DW] = {DW{1'b0}};        // [RULE_13]
      endcase
      gsel = pwm_mux[`CLRM_PM_SYNC_LSB+2*g +: 2];
      nxt_sync[g] = GEN_SYNC[gsel];                        // [RULE_10]
      gsel = pwm_mux[`CLRM_PM_RAMP_LSB+2*g +: 2];
      case (gsel)
        2'h0:    nxt_ramp[DW*g +: DW] = FE_RAMP[0 +: DW];    // [RULE_12]
        2'h1:    nxt_ramp[DW*g +: DW] = FE_RAMP[DW +: DW];   // [RULE_12]
        2'h2:    nxt_ramp[DW*g +: DW] = FE_RAMP[2*DW +: DW]; // [RULE_12]
        default: nxt_ramp[DW*g +: DW] = {DW{1'b0}};          // [RULE_13]
      endcase
    end
  end

  // ========================================================
  // Output registers
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FILT_FE_DATA    <= {3*DW{1'b0}};
      FILT_PERIOD     <= {3*DW{1'b0}};
      FILT_CONST      <= {3*14{1'b0}};
      FILT_FFWD       <= {3*DW{1'b0}};
      GEN_DUTY        <= {4*DW{1'b0}};
      GEN_MASTER_SYNC <= 4'h0;
      GEN_RAMP        <= {4*DW{1'b0}};
    end else begin
      FILT_FE_DATA    <= nxt_fe;
      FILT_PERIOD     <= nxt_per;
      FILT_CONST      <= nxt_const;
      FILT_FFWD       <= nxt_ffwd;
      GEN_DUTY        <= nxt_duty; // [RULE_09]
      GEN_MASTER_SYNC <= nxt_sync;
      GEN_RAMP        <= nxt_ramp;
    end
  end
endmodule

//--- tb/clrm_sva.sv
// Assertions on the routing register bank ports
`include "clrm_consts.vh"
module clrm_sva #(
  parameter DW = 14
) (
  input wire                    CORE_CLK,
  input wire                    RST_N,
  input wire [`CLRM_ADDR_W-1:0] ADDR,
  input wire [31:0]             WDATA,
  input wire                    WR_STB,
  input wire                    RD_STB,
  input wire [31:0]             RDATA,
  input wire [3*DW-1:0]         FE_DATA,
  input wire [3*DW-1:0]         FE_RAMP,
  input wire [4*DW-1:0]         GEN_PERIOD,
  input wire [3*DW-1:0]         FILT_OUT,
  input wire [3:0]              GEN_SYNC,
  input wire [DW-1:0]           CPOWER_OUT,
  input wire [DW-1:0]           LIGHT_LOAD_ON_TIME,
  input wire [3*DW-1:0]         FILT_FE_DATA,
  input wire [3*DW-1:0]         FILT_PERIOD,
  input wire [3*DW-1:0]         FILT_FFWD,
  input wire [4*DW-1:0]         GEN_DUTY,
  input wire [3:0]              GEN_MASTER_SYNC,
  input wire [4*DW-1:0]         GEN_RAMP
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // Shadow of the two mux words
  reg [31:0] fm_ff;
  reg [31:0] pm_ff;
  function automatic [DW-1:0] pk(input [5*DW-1:0] v, input [2:0] s,
                                 input [2:0] n);
    pk = (s < n) ? v[s*DW+:DW] : {DW{1'b0}};
  endfunction
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fm_ff <= `CLRM_RST_FILT_MUX;
      pm_ff <= `CLRM_RST_PWM_MUX;
    end else if (WR_STB && ADDR == `CLRM_OFS_FILT_MUX) begin
      fm_ff <= WDATA & `CLRM_MASK_FILT_MUX;
    end else if (WR_STB && ADDR == `CLRM_OFS_PWM_MUX) begin
      pm_ff <= WDATA & `CLRM_MASK_PWM_MUX;
    end
  end
  // ====================
  // Properties
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_rd(a);
    RD_STB && ADDR == a;
  endsequence
  a_read_filt: assert property (
    s_rd(`CLRM_OFS_FILT_MUX) |=> RDATA == $past(fm_ff)) else $error("fm read");
  a_read_pwm: assert property (
    s_rd(`CLRM_OFS_PWM_MUX) |=> RDATA == $past(pm_ff)) else $error("pm read");
  a_unmapped_read: assert property (RD_STB && !(ADDR inside {
    `CLRM_OFS_FILT_MUX, `CLRM_OFS_CONST_AB, `CLRM_OFS_CONST_C,
    `CLRM_OFS_PWM_MUX}) |=> RDATA == 32'h00000000) else $error("hole read");
  a_fe_route: assert property ($past(RST_N) |->
    FILT_FE_DATA[DW-1:0] == pk($past(FE_DATA), $past(fm_ff[1:0]), 3'h3))
    else $error("front end route");
  a_period_route: assert property ($past(RST_N) |->
    FILT_PERIOD[2*DW+:DW] ==
    pk($past(GEN_PERIOD), $past(fm_ff[13:12]), 3'h4)) else $error("period");
  a_ffwd_route: assert property ($past(RST_N) |->
    FILT_FFWD[DW-1:0] ==
    $past(fm_ff[16] ? FILT_OUT[2*DW+:DW] : FILT_OUT[DW+:DW]))
    else $error("feedforward route");
  a_duty_route: assert property ($past(RST_N) |->
    GEN_DUTY[3*DW+:DW] == pk($past({LIGHT_LOAD_ON_TIME, CPOWER_OUT,
    FILT_OUT}), $past(pm_ff[11:9]), 3'h5)) else $error("duty route");
  a_sync_route: assert property ($past(RST_N) |->
    GEN_MASTER_SYNC[1] == $past(GEN_SYNC[pm_ff[15:14]])) else $error("sync");
  a_ramp_route: assert property ($past(RST_N) |->
    GEN_RAMP[2*DW+:DW] == pk($past(FE_RAMP), $past(pm_ff[29:28]), 3'h3))
    else $error("ramp route");
endmodule

//--- tb/clrm_top_bench.sv
// Self-checking bench for the routing register bank
`include "clrm_consts.vh"
module clrm_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CORE_CLK, RST_N, WR_STB, RD_STB;
  logic [17:0] ADDR;
  logic [31:0] WDATA, RDATA, lfsr = 32'h9F6D5C75;
  logic [41:0] FE_DATA, FE_RAMP, FILT_OUT, FILT_FE_DATA, FILT_PERIOD;
  logic [41:0] FILT_CONST, FILT_FFWD;
  logic [55:0] GEN_PERIOD, GEN_DUTY, GEN_RAMP;
  logic [13:0] CPOWER_OUT, LIGHT_LOAD_ON_TIME;
  logic [3:0]  GEN_SYNC, GEN_MASTER_SYNC;
  logic [17:0] ofs[5] = '{`CLRM_OFS_FILT_MUX, `CLRM_OFS_CONST_AB,
                          `CLRM_OFS_CONST_C, `CLRM_OFS_PWM_MUX, 18'h20024};
  logic [31:0] mk[4] = '{`CLRM_MASK_FILT_MUX, `CLRM_MASK_CONST_AB,
                         `CLRM_MASK_CONST_C, `CLRM_MASK_PWM_MUX};
  logic [31:0] m[4] = '{`CLRM_RST_FILT_MUX, `CLRM_RST_CONST_AB,
                        `CLRM_RST_CONST_C, `CLRM_RST_PWM_MUX};
  int          bad_count, n_compared, cyc;
  clrm_top u_clrm_top (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
    .FE_DATA(FE_DATA), .FE_RAMP(FE_RAMP), .GEN_PERIOD(GEN_PERIOD),
    .FILT_OUT(FILT_OUT), .GEN_SYNC(GEN_SYNC), .CPOWER_OUT(CPOWER_OUT),
    .LIGHT_LOAD_ON_TIME(LIGHT_LOAD_ON_TIME), .FILT_FE_DATA(FILT_FE_DATA),
    .FILT_PERIOD(FILT_PERIOD), .FILT_CONST(FILT_CONST),
    .FILT_FFWD(FILT_FFWD), .GEN_DUTY(GEN_DUTY),
    .GEN_MASTER_SYNC(GEN_MASTER_SYNC), .GEN_RAMP(GEN_RAMP));
  // ====================
  // Helpers
  function automatic logic [31:0] rn();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [13:0] pk(logic [69:0] v, int s, int n);
    return s < n ? 14'(v >> 14 * s) : 14'h0000;
  endfunction
  task automatic chk(string nm, logic [55:0] seen, logic [55:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [17:0] a, logic [31:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    @(posedge CORE_CLK);
    WR_STB <= 1'b0;
    foreach (mk[i]) if (ofs[i] == a) m[i] = d & mk[i];
  endtask
  task automatic rd(logic [17:0] a);
    logic [31:0] e = 32'h00000000;
    foreach (mk[i]) if (ofs[i] == a) e = m[i];
    @(posedge CORE_CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CORE_CLK);
    RD_STB <= 1'b0;
    #1 chk("rdata", RDATA, e);
  endtask
  task automatic route();
    logic [31:0] f = m[0], p = m[3], s;
    logic [41:0] k = {m[2][13:0], m[1][29:16], m[1][13:0]};
    int b, n;
    for (int i = 0; i < 4; i++) begin
      b = 14 * i;
      s = p >> 2 * i;
      chk("duty", GEN_DUTY[b+:14], pk({LIGHT_LOAD_ON_TIME, CPOWER_OUT,
          FILT_OUT}, p[3*i+:3], 5));
      chk("sync", GEN_MASTER_SYNC[i], GEN_SYNC[s[13:12]]);
      chk("ramp", GEN_RAMP[b+:14], pk(FE_RAMP, s[25:24], 3));
      if (i < 3) begin
        s = f >> 2 * i;
        n = f[16+i] ? 2 - (i == 2) : (i == 0);
        chk("fe", FILT_FE_DATA[b+:14], pk(FE_DATA, s[1:0], 3));
        chk("per", FILT_PERIOD[b+:14], pk(GEN_PERIOD, s[9:8], 4));
        chk("kc", FILT_CONST[b+:14], pk(k, s[25:24], 3));
        chk("ff", FILT_FFWD[b+:14], pk(FILT_OUT, n, 3));
      end
    end
  endtask
  task automatic reset_run();
    RST_N <= 1'b0;
    m = '{`CLRM_RST_FILT_MUX, `CLRM_RST_CONST_AB,
          `CLRM_RST_CONST_C, `CLRM_RST_PWM_MUX};
    repeat (2) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    foreach (ofs[i]) rd(ofs[i]);
    route();
    $display("reset test done");
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ====================
  // Clock, watchdog, sequence
  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    {RST_N, WR_STB, RD_STB, ADDR, WDATA, FE_DATA, FE_RAMP, FILT_OUT} = 0;
    {GEN_PERIOD, GEN_SYNC, CPOWER_OUT, LIGHT_LOAD_ON_TIME} = 0;
    reset_run();
    repeat (80) begin
      wr(ofs[rn() % 5], rn());
      FE_DATA <= 42'({rn(), rn()});
      FE_RAMP <= 42'({rn(), rn()});
      FILT_OUT <= 42'({rn(), rn()});
      GEN_PERIOD <= 56'({rn(), rn()});
      GEN_SYNC <= 4'(rn());
      CPOWER_OUT <= 14'(rn());
      LIGHT_LOAD_ON_TIME <= 14'(rn());
      rd(ofs[rn() % 5]);
      route();
    end
    $display("random test done");
    reset_run();
    conclude();
  end
endmodule
bind clrm_top clrm_sva #(.DW(DW)) u_clrm_sva (.CORE_CLK(CORE_CLK),
  .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB),
  .RD_STB(RD_STB), .RDATA(RDATA), .FE_DATA(FE_DATA), .FILT_OUT(FILT_OUT),
  .GEN_PERIOD(GEN_PERIOD), .GEN_SYNC(GEN_SYNC), .CPOWER_OUT(CPOWER_OUT),
  .LIGHT_LOAD_ON_TIME(LIGHT_LOAD_ON_TIME), .FILT_FE_DATA(FILT_FE_DATA),
  .FILT_PERIOD(FILT_PERIOD), .FILT_FFWD(FILT_FFWD), .GEN_DUTY(GEN_DUTY),
  .GEN_MASTER_SYNC(GEN_MASTER_SYNC), .FE_RAMP(FE_RAMP),
  .GEN_RAMP(GEN_RAMP));
